// ### design/pit_timer.sv
// Periodic interval timer, count-up and count-down variants
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] Count-up: 20-bit counter increments every microsecond from halved 2 MHz
// [RULE2] At maximum, reload from reload value and signal terminal count
// [RULE3] Reloading never alters the reload value register
// [RULE4] One 64-bit register: full read, full write, status-only write
// [RULE5] Status 63..60, reload 59..40, counter 27..8, rest reserved
// [RULE6] Bit 63 runs the count-up counter; zero holds it
// [RULE7] Bit 62 gates interrupt while full flag is set
// [RULE8] Bit 61 reads full, writes decrement; bit 60 reads overflow
// [RULE9] Overflow/full saturating pseudocounter over states 00, 01, 11
// [RULE10] Interrupt delivery never changes full or overflow
// [RULE11] Processor gate flag also enables the count-up timer
// [RULE12] Count-down: four 16-bit registers at 0x20000000..0x20000018
// [RULE13] Count-down counter decrements once every ten microseconds
// [RULE14] Status bit 2 runs the counter; bits 15..3 reserved
// [RULE15] Underflow flag sets on underflow while empty already set
// [RULE16] Empty sets at each underflow; status read clears both
// [RULE17] Counter reloads at zero; counter and reload are read/write
// [RULE18] Low byte of channel register selects the interrupt channel
// [RULE19] Each underflow emits one-cycle request tagged with channel
// [RULE20] All registers reset to zero, timer halted
module pit_timer
    import pit_pkg::*;
#(
    parameter logic VARIANT = VARIANT_COUNT_DOWN
) (
    // Clock, reset, enable
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        clk_en_i,
    // Count-up 64-bit register access
    input  wire logic        up_rd_i,
    input  wire logic        up_wr_i,
    input  wire logic        up_wr_status_i,
    input  wire logic [63:0] up_wdata_i,
    output var  logic [63:0] up_rdata_o,
    input  wire logic        gate_flag_i,
    output var  logic        cpu_irq_o,
    // Count-down I/O access
    input  wire logic        io_rd_i,
    input  wire logic        io_wr_i,
    input  wire logic [31:0] io_addr_i,
    input  wire logic [15:0] io_wdata_i,
    output var  logic [15:0] io_rdata_o,
    output var  logic        io_ack_o,
    // Virtual interrupt channel request
    output var  logic        chan_req_o,
    output var  logic [7:0]  chan_num_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [19:0] up_cnt_q, up_cnt_d, up_nxt_q, up_nxt_d;
    logic        up_run_q, up_run_d, up_ien_q, up_ien_d;
    logic        up_ful_q, up_ful_d, up_ovf_q, up_ovf_d;
    logic        up_tc_q, up_tc_d;
    logic [15:0] dn_cnt_q, dn_cnt_d, dn_nxt_q, dn_nxt_d;
    logic        dn_run_q, dn_run_d, dn_unf_q, dn_unf_d;
    logic        dn_emp_q, dn_emp_d;
    logic [7:0]  chan_q, chan_d;
    logic [15:0] io_rdata_d;
    logic [63:0] up_rdata_d;
    logic        io_ack_d, chan_req_d, cpu_irq_d;
    logic        gate_s1_q, gate_s2_q;
    logic        up_tick, dn_tick, up_run_eff, dn_unf_ev;

    // Gate flag comes from the processor side: synchronise first
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gate_s1_q <= 1'b0;
            gate_s2_q <= 1'b0;
        end else if (clk_en_i) begin
            gate_s1_q <= gate_flag_i;
            gate_s2_q <= gate_s1_q;
        end
    end

    assign up_run_eff = (VARIANT == VARIANT_COUNT_UP) && up_run_q
                        && gate_s2_q; // [RULE6] [RULE11]

    // ------------------------------------------------------------------
    // Tick generators
    // ------------------------------------------------------------------
    pit_tick #(.PERIOD(UP_TICK_CYC)) u_up_tick (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .clk_en_i   (clk_en_i),
        .run_i      (up_run_eff),
        .tick_o     (up_tick)
    ); // [RULE1]

    pit_tick #(.PERIOD(DOWN_TICK_CYC)) u_dn_tick (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .clk_en_i   (clk_en_i),
        .run_i      ((VARIANT == VARIANT_COUNT_DOWN) && dn_run_q),
        .tick_o     (dn_tick)
    ); // [RULE13] [RULE14]

    // ------------------------------------------------------------------
    // Count-up next state
    // ------------------------------------------------------------------
    always_comb begin
        up_cnt_d = up_cnt_q;
        up_nxt_d = up_nxt_q; // Reload leaves this alone [RULE3]
        up_run_d = up_run_q;
        up_ien_d = up_ien_q;
        up_ful_d = up_ful_q;
        up_ovf_d = up_ovf_q;
        up_tc_d  = 1'b0;
        // Terminal count seen last cycle: reload on this clock
        if (up_tc_q) begin
            up_cnt_d = up_nxt_q; // [RULE2]
        end else if (up_tick && up_run_eff) begin // [RULE6]
            up_cnt_d = up_cnt_q + 20'h00001; // [RULE1]
            if (up_cnt_q + 20'h00001 == UP_CNT_MAX) begin
                up_tc_d = 1'b1; // [RULE2]
            end
        end
        if (up_wr_i) begin
            up_cnt_d = up_wdata_i[UP_CNT_LSB +: UP_CNT_W]; // [RULE4] [RULE5]
            up_nxt_d = up_wdata_i[UP_NXT_LSB +: UP_CNT_W];
        end
        if (up_wr_i || up_wr_status_i) begin
            up_run_d = up_wdata_i[UP_RUN_BIT]; // [RULE4]
            up_ien_d = up_wdata_i[UP_IEN_BIT];
        end
        // Pseudocounter: terminal count steps up, decrement steps down.
        // Both at once cancel out, so no event is lost. [RULE9] [RULE10]
        if (up_tc_d && !((up_wr_i || up_wr_status_i)
                         && up_wdata_i[UP_FUL_BIT])) begin
            up_ovf_d = up_ful_q;
            up_ful_d = 1'b1;
        end else if (!up_tc_d && (up_wr_i || up_wr_status_i)
                     && up_wdata_i[UP_FUL_BIT]) begin // [RULE8]
            up_ful_d = up_ovf_q;
            up_ovf_d = 1'b0;
        end
        if (VARIANT != VARIANT_COUNT_UP) begin
            up_tc_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin // [RULE20]
            up_cnt_q <= UP_CNT_RST;
            up_nxt_q <= UP_CNT_RST;
            up_run_q <= 1'b0;
            up_ien_q <= 1'b0;
            up_ful_q <= 1'b0;
            up_ovf_q <= 1'b0;
            up_tc_q  <= 1'b0;
        end else if (clk_en_i) begin
            up_cnt_q <= up_cnt_d;
            up_nxt_q <= up_nxt_d;
            up_run_q <= up_run_d;
            up_ien_q <= up_ien_d;
            up_ful_q <= up_ful_d;
            up_ovf_q <= up_ovf_d;
            up_tc_q  <= up_tc_d;
        end
    end

    // ------------------------------------------------------------------
    // Count-down next state
    // ------------------------------------------------------------------
    assign dn_unf_ev = dn_tick && dn_run_q && (dn_cnt_q == 16'h0001);

    always_comb begin
        dn_cnt_d   = dn_cnt_q;
        dn_nxt_d   = dn_nxt_q;
        dn_run_d   = dn_run_q;
        dn_unf_d   = dn_unf_q;
        dn_emp_d   = dn_emp_q;
        chan_d     = chan_q;
        chan_req_d = 1'b0;
        // Decrement; reaching zero reloads at once
        if (dn_tick && dn_run_q) begin // Late tick after a halt is dropped
            dn_cnt_d = dn_unf_ev ? dn_nxt_q
                                 : dn_cnt_q - 16'h0001; // [RULE13] [RULE17]
        end
        // Status read clears both flags; a new underflow wins
        if (io_rd_i && io_addr_i == ADDR_STATUS) begin
            dn_unf_d = 1'b0; // [RULE16]
            dn_emp_d = 1'b0;
        end
        if (dn_unf_ev) begin
            dn_emp_d   = 1'b1; // [RULE16]
            if (dn_emp_q) begin
                dn_unf_d = 1'b1; // [RULE15]
            end
            chan_req_d = 1'b1; // [RULE19]
        end
        if (io_wr_i) begin
            unique case (io_addr_i)
                ADDR_STATUS:  dn_run_d = io_wdata_i[DN_RUN_BIT]; // [RULE14]
                ADDR_RELOAD:  dn_nxt_d = io_wdata_i; // [RULE17]
                ADDR_COUNTER: dn_cnt_d = io_wdata_i; // [RULE17]
                ADDR_CHANNEL: chan_d   = io_wdata_i[CHAN_W-1:0]; // [RULE18]
                default: ;
            endcase
        end
        if (VARIANT != VARIANT_COUNT_DOWN) begin
            chan_req_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin // [RULE20]
            dn_cnt_q   <= DN_RST;
            dn_nxt_q   <= DN_RST;
            dn_run_q   <= 1'b0;
            dn_unf_q   <= 1'b0;
            dn_emp_q   <= 1'b0;
            chan_q     <= '0;
        end else if (clk_en_i) begin
            dn_cnt_q   <= dn_cnt_d;
            dn_nxt_q   <= dn_nxt_d;
            dn_run_q   <= dn_run_d;
            dn_unf_q   <= dn_unf_d;
            dn_emp_q   <= dn_emp_d;
            chan_q     <= chan_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data and outputs, all registered
    // ------------------------------------------------------------------
    always_comb begin
        io_rdata_d = '0;
        io_ack_d   = (io_rd_i || io_wr_i) && // [RULE12]
                     (io_addr_i == ADDR_STATUS || io_addr_i == ADDR_RELOAD ||
                      io_addr_i == ADDR_COUNTER || io_addr_i == ADDR_CHANNEL);
        if (io_rd_i) begin
            unique case (io_addr_i)
                ADDR_STATUS:  io_rdata_d = {13'h0000, dn_run_q, dn_unf_q,
                                            dn_emp_q}; // [RULE14]
                ADDR_RELOAD:  io_rdata_d = dn_nxt_q;
                ADDR_COUNTER: io_rdata_d = dn_cnt_q;
                ADDR_CHANNEL: io_rdata_d = {8'h00, chan_q}; // [RULE18]
                default:      io_rdata_d = '0;
            endcase
        end
        up_rdata_d = up_rdata_o;
        if (up_rd_i) begin
            up_rdata_d = {up_run_q, up_ien_q, up_ful_q, up_ovf_q, up_nxt_q,
                          1'b0, 11'h000, up_cnt_q, 8'h00}; // [RULE5] [RULE8]
        end
        cpu_irq_d = up_ien_d && up_ful_d; // [RULE7]
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            io_rdata_o <= '0;
            io_ack_o   <= 1'b0;
            up_rdata_o <= '0;
            cpu_irq_o  <= 1'b0;
            chan_req_o <= 1'b0;
            chan_num_o <= '0;
        end else if (clk_en_i) begin
            io_rdata_o <= io_rdata_d;
            io_ack_o   <= io_ack_d;
            up_rdata_o <= up_rdata_d;
            cpu_irq_o  <= cpu_irq_d;
            chan_req_o <= chan_req_d;
            chan_num_o <= chan_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    reload_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && !up_wr_i |=> $stable(up_nxt_q)) // [RULE3]
        else $error("reload value changed without a write");

    psc_legal_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !(up_ovf_q && !up_ful_q)) // [RULE9]
        else $error("pseudocounter in state 10");

    tc_reload_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && up_tc_q && !up_wr_i |=> up_cnt_q == $past(up_nxt_q))
        // [RULE2]
        else $error("counter not reloaded after terminal count");

    irq_gate_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        clk_en_i |=> cpu_irq_o == (up_ien_q && up_ful_q)) // [RULE7]
        else $error("interrupt output not gated by enable and full");

    up_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && !up_run_q && !up_wr_i && !up_tc_q |=> $stable(up_cnt_q))
        // [RULE6]
        else $error("counter moved while halted");

    dn_halt_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && !dn_run_q && !io_wr_i |=> $stable(dn_cnt_q)) // [RULE14]
        else $error("count-down counter moved while halted");

    dn_empty_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && dn_unf_ev |=> dn_emp_q && chan_req_o
                                  && dn_cnt_q == $past(dn_nxt_q))
        // [RULE16]
        else $error("underflow did not set empty and request");

    dn_miss_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && dn_unf_ev && dn_emp_q |=> dn_unf_q) // [RULE15]
        else $error("missed service not recorded");

    rd_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && io_rd_i && io_addr_i == ADDR_STATUS && !dn_unf_ev
        |=> !dn_emp_q && !dn_unf_q) // [RULE16]
        else $error("status read did not clear flags");

    req_pulse_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        chan_req_o && clk_en_i |=> !chan_req_o) // [RULE19]
        else $error("channel request longer than one cycle");
endmodule : pit_timer
`default_nettype wire

// ### design/pit_pkg.sv
// Package: constants for the periodic interval timer
package pit_pkg;
    // ------------------------------------------------------------------
    // Variant selection
    // ------------------------------------------------------------------
    localparam logic VARIANT_COUNT_UP   = 1'b0;
    localparam logic VARIANT_COUNT_DOWN = 1'b1;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 20_000_000;
    localparam int SRC_CLK_HZ      = 2_000_000;   // Count-up source clock
    localparam int SRC_DIV         = 2;           // Halved to 1 MHz
    localparam int UP_TICK_CYC     = (CLK_HZ / SRC_CLK_HZ) * SRC_DIV;
    localparam int DOWN_TICK_US    = 10;
    localparam int DOWN_TICK_CYC   = (CLK_HZ / 1_000_000) * DOWN_TICK_US;
    localparam int PRE_W           = 8;

    // ------------------------------------------------------------------
    // Count-up 64-bit view
    // ------------------------------------------------------------------
    localparam int UP_CNT_W   = 20;
    localparam int UP_CNT_LSB = 8;
    localparam int UP_NXT_LSB = 40;
    localparam int UP_RUN_BIT = 63;
    localparam int UP_IEN_BIT = 62;
    localparam int UP_FUL_BIT = 61;
    localparam int UP_OVF_BIT = 60;
    localparam logic [19:0] UP_CNT_MAX = 20'hfffff;
    localparam logic [19:0] UP_CNT_RST = 20'h00000;

    // ------------------------------------------------------------------
    // Count-down register map (I/O byte addresses)
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_STATUS  = 32'h2000_0000;
    localparam logic [31:0] ADDR_RELOAD  = 32'h2000_0008;
    localparam logic [31:0] ADDR_COUNTER = 32'h2000_0010;
    localparam logic [31:0] ADDR_CHANNEL = 32'h2000_0018;
    localparam int DN_W        = 16;
    localparam int DN_RUN_BIT  = 2;
    localparam int DN_UNF_BIT  = 1;
    localparam int DN_EMP_BIT  = 0;
    localparam int CHAN_W      = 8;
    localparam logic [15:0] DN_RST = 16'h0000;
endpackage : pit_pkg

// ### design/pit_tick.sv
// Tick prescaler: one-cycle pulse every PERIOD enabled cycles
`timescale 1ns/1ps
`default_nettype none
module pit_tick
    import pit_pkg::*;
#(
    parameter int PERIOD = 20
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic clk_en_i,
    // Control
    input  wire logic run_i,
    output var  logic tick_o
);
    localparam logic [PRE_W-1:0] LAST = PRE_W'(PERIOD - 1);

    logic [PRE_W-1:0] cnt_q, cnt_d;
    logic             tick_q, tick_d;

    // ------------------------------------------------------------------
    // Next state: free phase restarts while halted
    // ------------------------------------------------------------------
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!run_i) begin
            cnt_d = '0;
        end else if (cnt_q == LAST) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + PRE_W'(1);
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (clk_en_i) begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q & clk_en_i;
endmodule : pit_tick
`default_nettype wire

// ### tb/pit_cpu_model.sv
// Processor-side model: gate flag and virtual interrupt channels
`timescale 1ns/1ps
`default_nettype none
module pit_cpu_model (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    // Timer side
    input  wire logic         chan_req_i,
    input  wire logic [7:0]   chan_num_i,
    output var  logic         gate_flag_o,
    // Software controls and observed counts
    input  wire logic         gate_cmd_i,
    input  wire logic [255:0] chan_en_i,
    output var  int           req_cnt_o,
    output var  int           irq_cnt_o,
    output var  int           gap_o,
    output var  logic [7:0]   last_num_o
);
    int age_q;

    // ------------------------------------------------------------
    // Gate flag
    // ------------------------------------------------------------
    // The processor owns this flag; low in reset keeps timer idle
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i)
            gate_flag_o <= 1'b0;
        else
            gate_flag_o <= gate_cmd_i;
    end

    // ------------------------------------------------------------
    // Channel logic
    // ------------------------------------------------------------
    // Every request is counted, but a disabled channel swallows it:
    // software can also silence the timer by clearing status bit 2, which halts it
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            req_cnt_o  <= 0;
            irq_cnt_o  <= 0;
            gap_o      <= 0;
            age_q      <= 0;
            last_num_o <= 8'h00;
        end else if (chan_req_i) begin
            req_cnt_o  <= req_cnt_o + 1;
            gap_o      <= age_q + 1;
            age_q      <= 0;
            last_num_o <= chan_num_i;
            if (chan_en_i[chan_num_i])
                irq_cnt_o <= irq_cnt_o + 1;
        end else begin
            age_q <= age_q + 1;
        end
    end
endmodule : pit_cpu_model
`default_nettype wire

// ### tb/pit_timer_bench.sv
// Self-checking bench for both variants of the interval timer
`timescale 1ns/1ps
`default_nettype none
module pit_timer_bench;
    import pit_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic         core_clk_i, reset_i, up_rd_i, up_wr_i, up_wr_status_i;
    logic [63:0]  up_wdata_i, up_rdata_o;
    logic         gate_flag, gate_cmd, cpu_irq_o, io_rd_i, io_wr_i;
    logic [31:0]  io_addr_i;
    logic [15:0]  io_wdata_i, io_rdata_o, rnd, rl, ch;
    logic         io_ack_o, chan_req_o, rd_d, up_d, clk_en;
    logic [7:0]   chan_num_o, last_num;
    logic [255:0] chan_en;
    int           req_cnt, irq_cnt, gap, fail_count, total_checks;
    logic [16:0]  io_q[$];
    logic [127:0] up_q[$];
    logic [127:0] ue;
    logic [31:0]  addrs[4] = '{ADDR_STATUS, ADDR_RELOAD, ADDR_COUNTER,
                               ADDR_CHANNEL};
    logic [3:0]   wn[6] = '{4'hc, 4'hc, 4'hc, 4'h6, 4'h6, 4'h6};
    logic [3:0]   en[6] = '{4'he, 4'hf, 4'hf, 4'h6, 4'h4, 4'h4};

    // ------------------------------------------------------------
    // Instances: count-down and count-up share the stimulus
    // ------------------------------------------------------------
    pit_timer i_dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
        .up_rd_i(up_rd_i), .up_wr_i(up_wr_i),
        .up_wr_status_i(up_wr_status_i), .up_wdata_i(up_wdata_i),
        .up_rdata_o(), .gate_flag_i(gate_flag), .cpu_irq_o(),
        .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_addr_i(io_addr_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
        .io_ack_o(io_ack_o), .chan_req_o(chan_req_o),
        .chan_num_o(chan_num_o));
    pit_timer #(.VARIANT(VARIANT_COUNT_UP)) i_dut_up (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
        .up_rd_i(up_rd_i), .up_wr_i(up_wr_i),
        .up_wr_status_i(up_wr_status_i), .up_wdata_i(up_wdata_i),
        .up_rdata_o(up_rdata_o), .gate_flag_i(gate_flag),
        .cpu_irq_o(cpu_irq_o), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
        .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(),
        .io_ack_o(), .chan_req_o(), .chan_num_o());
    pit_cpu_model i_cpu (
        .core_clk_i(core_clk_i), .reset_i(reset_i),
        .chan_req_i(chan_req_o), .chan_num_i(chan_num_o),
        .gate_flag_o(gate_flag), .gate_cmd_i(gate_cmd),
        .chan_en_i(chan_en), .req_cnt_o(req_cnt), .irq_cnt_o(irq_cnt),
        .gap_o(gap), .last_num_o(last_num));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic io_w(input logic [31:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        io_wr_i    <= 1'b1;
        io_addr_i  <= a;
        io_wdata_i <= d;
        @(posedge core_clk_i);
        io_wr_i <= 1'b0;
    endtask : io_w

    // Expected value carries the ack bit on top of the data
    task automatic io_r(input logic [31:0] a, input logic [16:0] e);
        @(posedge core_clk_i);
        io_rd_i   <= 1'b1;
        io_addr_i <= a;
        io_q.push_back(e);
        @(posedge core_clk_i);
        io_rd_i <= 1'b0;
    endtask : io_r

    task automatic up_w(input logic st, input logic [63:0] d);
        @(posedge core_clk_i);
        up_wr_i        <= !st;
        up_wr_status_i <= st;
        up_wdata_i     <= d;
        @(posedge core_clk_i);
        up_wr_i        <= 1'b0;
        up_wr_status_i <= 1'b0;
    endtask : up_w

    task automatic up_r(input logic [63:0] m, input logic [63:0] e);
        @(posedge core_clk_i);
        up_rd_i <= 1'b1;
        up_q.push_back({m, e});
        @(posedge core_clk_i);
        up_rd_i <= 1'b0;
    endtask : up_r

    // Bounded wait for the n-th channel request
    task automatic wait_req(input int n);
        for (int i = 0; i < 4000; i++) begin
            if (req_cnt >= n)
                return;
            @(posedge core_clk_i);
        end
        fail_count++;
        stop_test();
    endtask : wait_req

    // ------------------------------------------------------------
    // Clock, watchdog and result monitor
    // ------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    initial begin
        repeat (60000) @(posedge core_clk_i);
        fail_count++;
        stop_test();
    end

    // Answers land one cycle after the take edge; oldest note first
    always @(posedge core_clk_i) begin
        rd_d <= io_rd_i;
        up_d <= up_rd_i;
        if (rd_d && io_q.size() > 0)
            check(64'({io_ack_o, io_rdata_o}), 64'(io_q.pop_front()));
        if (up_d && up_q.size() > 0) begin
            ue = up_q.pop_front();
            check(up_rdata_o & ue[127:64], ue[63:0]);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {up_rd_i, up_wr_i, up_wr_status_i, io_rd_i, io_wr_i} = '0;
        {up_wdata_i, io_addr_i, io_wdata_i} = '0;
        clk_en       = 1'b1;
        fail_count   = 0;
        total_checks = 0;
        chan_en      = '1;
        gate_cmd     = 1'b1;
        reset_i      = 1'b1;
        rnd          = 16'hec56; // Seed 60502
        repeat (8) @(posedge core_clk_i);
        reset_i <= 1'b0;
        // Count-down: reset values and unmapped holes
        foreach (addrs[i]) io_r(addrs[i], 17'h10000);
        io_r(32'h2000_0004, 17'h00000);
        io_r(32'h2000_0020, 17'h00000);
        rnd = lfsr(rnd);
        rl  = {14'h0, rnd[1:0]} + 16'h0002;
        rnd = lfsr(rnd);
        ch  = {8'h00, rnd[7:0]};
        io_w(ADDR_RELOAD, rl);
        io_w(ADDR_CHANNEL, ch);
        io_w(ADDR_COUNTER, 16'h0002);
        io_r(ADDR_RELOAD, {1'b1, rl});
        io_r(ADDR_COUNTER, 17'h10002);
        io_r(ADDR_CHANNEL, {1'b1, ch});
        // Flag and reserved bits are write-ignored
        io_w(ADDR_STATUS, 16'hffff);
        io_r(ADDR_STATUS, 17'h10004);
        wait_req(1);
        io_r(ADDR_STATUS, 17'h10005);
        wait_req(2);
        @(negedge core_clk_i);
        check(64'(gap), 64'(int'(rl) * DOWN_TICK_CYC));
        check(64'(last_num), 64'(ch[7:0]));
        check(64'(irq_cnt), 64'd2);
        chan_en[ch[7:0]] = 1'b0;
        // Missed service: two underflows with no status read between
        wait_req(3);
        io_r(ADDR_STATUS, 17'h10007);
        io_r(ADDR_STATUS, 17'h10004);
        @(negedge core_clk_i);
        check(64'(irq_cnt), 64'd2);
        io_w(ADDR_STATUS, 16'hfff8);
        io_w(ADDR_COUNTER, 16'h0009);
        repeat (600) @(posedge core_clk_i);
        io_r(ADDR_COUNTER, 17'h10009);
        io_r(ADDR_STATUS, 17'h10000);
        // Second reset in mid-run
        io_w(ADDR_STATUS, 16'h0004);
        // Enable low freezes the running counter and its prescaler
        clk_en <= 1'b0;
        repeat (600) @(posedge core_clk_i);
        clk_en <= 1'b1;
        io_r(ADDR_COUNTER, 17'h10009);
        repeat (300) @(posedge core_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        foreach (addrs[i]) io_r(addrs[i], 17'h10000);
        // Count-up: terminal counts, then decrement writes
        for (int i = 0; i < 6; i++) begin
            up_w(i > 2, i > 2 ? {wn[i], 60'h0}
                              : {wn[i], 20'habcde, 12'h0, 20'hffffe, 8'h00});
            repeat (100) @(posedge core_clk_i);
            up_r(64'hffffff00_00000000, {en[i], 20'habcde, 40'h0});
            @(negedge core_clk_i);
            check(64'(cpu_irq_o), 64'(en[i][2] & en[i][1]));
        end
        // Halted counter holds, full layout read back
        up_w(1'b0, {4'h0, 20'h12345, 12'h0, 20'hffffe, 8'h00});
        repeat (100) @(posedge core_clk_i);
        up_r(64'hffffffff_ffffff00,
             {4'h0, 20'h12345, 12'h0, 20'hffffe, 8'h00});
        // Run set but processor gate low: still no counting
        gate_cmd <= 1'b0;
        up_w(1'b0, {4'h8, 20'h0, 12'h0, 20'hffffe, 8'h00});
        repeat (100) @(posedge core_clk_i);
        up_r(64'hffffffff_ffffff00,
             {4'h8, 20'h0, 12'h0, 20'hffffe, 8'h00});
        repeat (4) @(posedge core_clk_i);
        stop_test();
    end
endmodule : pit_timer_bench
`default_nettype wire
